// *** iss_master_model.sv ***
// behavioural two-wire bus master that faces the slave under test
// assumes both lines are resolved by the bench with pull-ups; it only ever pulls low
`timescale 1ns/10ps
`default_nettype none
module iss_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_dn,
  output logic      sda_dn
);
  initial begin
    scl_dn = 1'b0;
    sda_dn = 1'b0;
  end

  // one clock: data set mid-low, any stretch waited out, sampled mid-high
  task automatic bit_clk(input logic drv, output logic smp);
    #25 sda_dn = ~drv;
    #25 scl_dn = 1'b0;
    wait (scl === 1'b1);
    #15 smp = sda;
    #15 scl_dn = 1'b1;
  endtask

  task automatic start();
    sda_dn = 1'b1;
    #20 scl_dn = 1'b1;
  endtask

  task automatic stop();
    #25 sda_dn = 1'b1;
    #25 scl_dn = 1'b0;
    wait (scl === 1'b1);
    #15 sda_dn = 1'b0;
    #40;
  endtask

  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_clk(b[i], s);
  endtask

  task automatic recv(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_clk(1'b1, b[i]);
  endtask
endmodule
`default_nettype wire

// *** iss_pkg.sv ***
// constants and types shared by the two-wire slave block
// assumes a 32-bit classic wishbone register bus and a 100 MHz core clock
package iss_pkg;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_ADDR   = 8'h0C;
  localparam logic [7:0] OFS_TOC    = 8'h10;
  localparam logic [7:0] OFS_IRQ    = 8'h14;
  localparam logic [2:0] MODE_BUS   = 3'h6;
  localparam logic [2:0] MODE_POR   = 3'h7;
  localparam int         CTRL_MLSB  = 5;
  localparam int         CTRL_EN    = 1;
  localparam int         TOC_EN     = 7;
  localparam int         TOC_FLAG   = 6;
  localparam int         IRQ_EN     = 0;
  localparam int         IRQ_PEND   = 1;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  // one time-out unit: 32 periods of the slow sub clock
  localparam int         TO_UNIT_NS = 1000000;
  localparam int         CLK_NS     = 10;
  localparam int         TO_UNIT_CYC = TO_UNIT_NS / CLK_NS;

  typedef struct packed {
    logic xfer_complete_flag;
    logic addr_match_flag;
    logic bus_busy_flag;
    logic slave_tx_select;
    logic ack_out_bit;
    logic master_rw_flag;
    logic wake_on_match_en;
    logic ack_in_flag;
  } iss_status_s;

  localparam iss_status_s STAT_POR = 8'h81;

  typedef struct packed {
    logic scl;
    logic sda;
  } iss_pins_s;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_AACK = 8'h04,
    ST_HOLD = 8'h08,
    ST_RX   = 8'h10,
    ST_RACK = 8'h20,
    ST_TX   = 8'h40,
    ST_TACK = 8'h80
  } iss_state_e;
endpackage

// *** iss_slave.sv ***
// two-wire bus slave: status/control flags, address match, stretch, time-out
// assumes open-drain pins resolved outside and a classic wishbone master
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module iss_slave #(
  parameter int TO_UNIT_CYC = iss_pkg::TO_UNIT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_o,
  output logic             scl_oe,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             serial_irq,
  output logic             wake_req
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  iss_pkg::iss_pins_s   s1, s2, s3;
  iss_pkg::iss_status_s stat, next_stat;
  iss_pkg::iss_state_e  st, next_st;
  logic [2:0]  mode, next_mode;
  logic        en, next_en;
  logic        ok_d;
  logic [7:0]  data, next_data;
  logic [7:0]  own, next_own;
  logic [7:0]  toc, next_toc;
  logic        irq_en, next_irq_en;
  logic        pend, next_pend;
  logic [3:0]  cnt, next_cnt;
  logic [7:0]  sh, next_sh;
  logic        sda_low, next_sda_low;
  logic        scl_low, next_scl_low;
  logic [16:0] pre, next_pre;
  logic [5:0]  tcnt, next_tcnt;
  logic [31:0] next_rdat;
  logic        tout;

  // pins pass two flip-flops; s3 only serves edge finding on s2
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
    end else begin
      s1 <= '{scl: scl_i, sda: sda_i};
      s2 <= s1;
      s3 <= s2;
    end
  end

  wire scl_rise = s2.scl & ~s3.scl;
  wire scl_fall = ~s2.scl & s3.scl;
  wire start    = s2.scl & s3.scl & s3.sda & ~s2.sda;
  wire stop     = s2.scl & s3.scl & ~s3.sda & s2.sda;
  wire bus_ok   = en & (mode == iss_pkg::MODE_BUS);
  wire acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr       = acc & wb_we_i & wb_sel_i[0];
  wire rd       = acc & ~wb_we_i;
  wire data_acc = (wr | rd) & hit(wb_adr_i, iss_pkg::OFS_DATA);
  wire addr_eq  = sh[6:0] == own[7:1];

  always_comb begin
    next_mode    = mode;
    next_en      = en;
    next_stat    = stat;
    next_data    = data;
    next_own     = own;
    next_toc     = toc;
    next_irq_en  = irq_en;
    next_pend    = pend;
    next_st      = st;
    next_cnt     = cnt;
    next_sh      = sh;
    next_sda_low = sda_low;
    next_scl_low = scl_low;
    next_pre     = pre;
    next_tcnt    = tcnt;
    tout         = 1'b0;
    next_rdat    = 32'h0;
    if (rd) begin
      if (hit(wb_adr_i, iss_pkg::OFS_CTRL)) begin
        next_rdat[7:0] = {mode, 3'h0, en, 1'b0};
      end else if (hit(wb_adr_i, iss_pkg::OFS_STAT)) begin
        next_rdat[7:0] = stat;
      end else if (hit(wb_adr_i, iss_pkg::OFS_DATA)) begin
        next_rdat[7:0] = data;
      end else if (hit(wb_adr_i, iss_pkg::OFS_ADDR)) begin
        next_rdat[7:0] = own;
      end else if (hit(wb_adr_i, iss_pkg::OFS_TOC)) begin
        next_rdat[7:0] = toc;
      end else if (hit(wb_adr_i, iss_pkg::OFS_IRQ)) begin
        next_rdat[7:0] = {6'h0, pend, irq_en};
      end
    end
    if (wr) begin
      if (hit(wb_adr_i, iss_pkg::OFS_CTRL)) begin
        next_mode = wb_dat_i[iss_pkg::CTRL_MLSB +: 3];
        next_en   = wb_dat_i[iss_pkg::CTRL_EN];
      end else if (hit(wb_adr_i, iss_pkg::OFS_STAT)) begin
        next_stat.slave_tx_select   = wb_dat_i[4];
        next_stat.ack_out_bit  = wb_dat_i[3];
        next_stat.wake_on_match_en = wb_dat_i[1];
      end else if (hit(wb_adr_i, iss_pkg::OFS_DATA)) begin
        next_data = wb_dat_i[7:0];
      end else if (hit(wb_adr_i, iss_pkg::OFS_ADDR)) begin
        next_own = wb_dat_i[7:0];
      end else if (hit(wb_adr_i, iss_pkg::OFS_TOC)) begin
        next_toc = wb_dat_i[7:0];
      end else if (hit(wb_adr_i, iss_pkg::OFS_IRQ)) begin
        next_irq_en = wb_dat_i[iss_pkg::IRQ_EN];
        if (wb_dat_i[iss_pkg::IRQ_PEND]) begin
          next_pend = 1'b0;
        end
      end
    end
    if (bus_ok && !ok_d) begin
      next_stat.xfer_complete_flag  = iss_pkg::STAT_POR.xfer_complete_flag;
      next_stat.addr_match_flag = 1'b0;
      next_stat.bus_busy_flag  = 1'b0;
      next_stat.master_rw_flag  = 1'b0;
      next_stat.ack_in_flag = iss_pkg::STAT_POR.ack_in_flag;
    end
    if (!bus_ok) begin
      next_st      = iss_pkg::ST_IDLE;
      next_sda_low = 1'b0;
      next_scl_low = 1'b0;
    end else if (stop) begin
      next_stat.bus_busy_flag = 1'b0;
      next_st       = iss_pkg::ST_IDLE;
      next_sda_low  = 1'b0;
      next_scl_low  = 1'b0;
    end else if (start) begin
      next_stat.bus_busy_flag  = 1'b1;
      next_stat.xfer_complete_flag  = 1'b0;
      next_stat.addr_match_flag = 1'b0;
      next_st        = iss_pkg::ST_ADDR;
      next_cnt       = 4'h0;
      next_sda_low   = 1'b0;
      next_scl_low   = 1'b0;
    end else begin
      case (st)
        iss_pkg::ST_ADDR: begin
          if (scl_rise) begin
            next_sh  = {sh[6:0], s2.sda};
            next_cnt = cnt + 4'h1;
            if (cnt == iss_pkg::LAST_BIT) begin
              next_stat.master_rw_flag = s2.sda;
              if (addr_eq) begin
                next_stat.addr_match_flag = 1'b1;
                next_pend      = 1'b1;
              end
            end
          end else if (scl_fall && cnt == iss_pkg::BYTE_BITS) begin
            if (stat.addr_match_flag) begin
              next_st      = iss_pkg::ST_AACK;
              next_sda_low = 1'b1;
            end else begin
              next_st = iss_pkg::ST_IDLE;
            end
          end
        end
        iss_pkg::ST_AACK: begin
          if (scl_fall) begin
            next_st      = iss_pkg::ST_HOLD;
            next_sda_low = 1'b0;
            next_scl_low = 1'b1;
          end
        end
        iss_pkg::ST_HOLD: begin
          if (data_acc) begin
            next_scl_low  = 1'b0;
            next_cnt      = 4'h0;
            next_stat.xfer_complete_flag = 1'b0;
            if (stat.slave_tx_select) begin
              next_st      = iss_pkg::ST_TX;
              next_sh      = next_data;
              next_sda_low = ~next_data[7];
            end else begin
              next_st = iss_pkg::ST_RX;
            end
          end
        end
        iss_pkg::ST_RX: begin
          if (scl_rise) begin
            next_sh  = {sh[6:0], s2.sda};
            next_cnt = cnt + 4'h1;
            if (cnt == iss_pkg::LAST_BIT) begin
              next_data     = {sh[6:0], s2.sda};
              next_stat.xfer_complete_flag = 1'b1;
              next_pend     = 1'b1;
            end
          end else if (scl_fall && cnt == iss_pkg::BYTE_BITS) begin
            next_st      = iss_pkg::ST_RACK;
            next_sda_low = ~stat.ack_out_bit;
          end
        end
        iss_pkg::ST_RACK: begin
          if (scl_fall) begin
            next_st        = iss_pkg::ST_RX;
            next_sda_low   = 1'b0;
            next_cnt       = 4'h0;
            next_stat.xfer_complete_flag  = 1'b0;
            next_stat.addr_match_flag = 1'b0;
          end
        end
        iss_pkg::ST_TX: begin
          if (scl_fall) begin
            next_cnt = cnt + 4'h1;
            next_sh  = {sh[6:0], 1'b0};
            if (cnt == iss_pkg::LAST_BIT) begin
              next_st      = iss_pkg::ST_TACK;
              next_sda_low = 1'b0;
            end else begin
              next_sda_low = ~sh[6];
            end
          end
        end
        iss_pkg::ST_TACK: begin
          if (scl_rise) begin
            next_stat.ack_in_flag = s2.sda;
            next_stat.xfer_complete_flag  = 1'b1;
            next_pend      = 1'b1;
          end else if (scl_fall) begin
            if (!stat.ack_in_flag) begin
              next_st        = iss_pkg::ST_TX;
              next_cnt       = 4'h0;
              next_sh        = data;
              next_sda_low   = ~data[7];
              next_stat.xfer_complete_flag  = 1'b0;
              next_stat.addr_match_flag = 1'b0;
            end else begin
              next_st = iss_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          next_st = iss_pkg::ST_IDLE;
        end
      endcase
    end
    // time-out runs from the address match until the slave is back in ST_IDLE or ST_ADDR; scl falling restarts it
    if (!toc[iss_pkg::TOC_EN] || st == iss_pkg::ST_IDLE || st == iss_pkg::ST_ADDR || scl_fall) begin
      next_pre  = 17'h0;
      next_tcnt = 6'h0;
    end else if (pre == 17'(TO_UNIT_CYC - 1)) begin
      next_pre  = 17'h0;
      next_tcnt = tcnt + 6'h1;
      tout      = bus_ok && tcnt == toc[5:0];
    end else begin
      next_pre = pre + 17'h1;
    end
    if (tout) begin
      next_stat                   = iss_pkg::STAT_POR;
      next_toc[iss_pkg::TOC_EN]   = 1'b0;
      next_toc[iss_pkg::TOC_FLAG] = 1'b1;
      next_pend                   = 1'b1;
      next_st                     = iss_pkg::ST_IDLE;
      next_sda_low                = 1'b0;
      next_scl_low                = 1'b0;
      next_pre                    = 17'h0;
      next_tcnt                   = 6'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode     <= iss_pkg::MODE_POR;
      en       <= 1'b0;
      ok_d     <= 1'b0;
      stat     <= iss_pkg::STAT_POR;
      data     <= 8'h00;
      own      <= 8'h00;
      toc      <= 8'h00;
      irq_en   <= 1'b0;
      pend     <= 1'b0;
      st       <= iss_pkg::ST_IDLE;
      cnt      <= 4'h0;
      sh       <= 8'h00;
      sda_low  <= 1'b0;
      scl_low  <= 1'b0;
      pre      <= 17'h0;
      tcnt     <= 6'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      mode     <= next_mode;
      en       <= next_en;
      ok_d     <= bus_ok;
      stat     <= next_stat;
      data     <= next_data;
      own      <= next_own;
      toc      <= next_toc;
      irq_en   <= next_irq_en;
      pend     <= next_pend;
      st       <= next_st;
      cnt      <= next_cnt;
      sh       <= next_sh;
      sda_low  <= next_sda_low;
      scl_low  <= next_scl_low;
      pre      <= next_pre;
      tcnt     <= next_tcnt;
      wb_ack_o <= acc;
      wb_dat_o <= next_rdat;
    end
  end

  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe     = scl_low & bus_ok;
  assign sda_oe     = sda_low & bus_ok;
  assign serial_irq = pend & irq_en;
  assign wake_req   = stat.addr_match_flag & stat.wake_on_match_en;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_byte_done;
    (st == iss_pkg::ST_RX && scl_rise && cnt == iss_pkg::LAST_BIT && bus_ok && !tout)
      |=> stat.xfer_complete_flag && pend;
  endproperty
  a_byte_done: assert property (p_byte_done) else $error("byte end lacks flag");

  property p_no_match;
    (st == iss_pkg::ST_ADDR && scl_rise && cnt == iss_pkg::LAST_BIT && bus_ok && !addr_eq)
      |=> !stat.addr_match_flag;
  endproperty
  a_no_match: assert property (p_no_match) else $error("match flag on wrong address");

  property p_busy;
    (bus_ok && start && !tout) |=> stat.bus_busy_flag ##1 (stat.bus_busy_flag || $past(stop) || !$past(bus_ok));
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set on start");

  property p_ack_out;
    (st == iss_pkg::ST_RX && scl_fall && cnt == iss_pkg::BYTE_BITS && bus_ok && !tout)
      |=> st == iss_pkg::ST_RACK && sda_low == !$past(stat.ack_out_bit);
  endproperty
  a_ack_out: assert property (p_ack_out) else $error("ack out level wrong");

  property p_rw;
    (st == iss_pkg::ST_ADDR && scl_rise && cnt == iss_pkg::LAST_BIT && bus_ok)
      |=> stat.master_rw_flag == $past(s2.sda);
  endproperty
  a_rw: assert property (p_rw) else $error("read/write bit not captured");

  property p_addr_ack;
    (st == iss_pkg::ST_AACK && bus_ok) |-> sda_oe && stat.addr_match_flag;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack not driven");

  property p_ack_in;
    (st == iss_pkg::ST_TACK && scl_rise && bus_ok && !tout)
      |=> stat.ack_in_flag == $past(s2.sda) && stat.xfer_complete_flag;
  endproperty
  a_ack_in: assert property (p_ack_in) else $error("ack in not sampled");

  property p_nack_release;
    (st == iss_pkg::ST_TACK && scl_fall && stat.ack_in_flag && bus_ok && !start && !stop && !tout)
      |=> st == iss_pkg::ST_IDLE && !sda_oe;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("line kept after nack");

  property p_stretch;
    (st == iss_pkg::ST_HOLD && bus_ok && !data_acc && !start && !stop && !tout)
      |=> scl_oe && st == iss_pkg::ST_HOLD;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held");

  property p_timeout;
    tout |=> toc[iss_pkg::TOC_FLAG] && !toc[iss_pkg::TOC_EN] && pend && st == iss_pkg::ST_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out effects missing");

  property p_quiet;
    !bus_ok |-> !sda_oe && !scl_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin driven while off");
endmodule
`default_nettype wire

// *** iss_slave_tb.sv ***
// self-checking bench for the two-wire slave: bus driver, link master, read monitor
// assumes iss_pkg, iss_slave and iss_master_model are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      fail_count++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module iss_slave_tb;
  localparam int TO = 20;
  typedef struct packed {
    logic [7:0] mk;
    logic [7:0] v;
  } iss_note_s;
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [31:0] dat      = 32'h0;
  logic        we       = 1'b0;
  logic        stb      = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, scl_o, scl_oe, sda_o, sda_oe, serial_irq, wake_req;
  logic        scl_dn, sda_dn, scl_w, sda_w, s;
  logic [6:0]  own;
  logic [7:0]  d0, d1, b;
  iss_note_s   nt;
  iss_note_s   notes[$];
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  assign scl_w = !(scl_dn || (scl_oe && !scl_o));
  assign sda_w = !(sda_dn || (sda_oe && !sda_o));
  always #5 core_clk = ~core_clk;

  iss_slave #(.TO_UNIT_CYC(TO)) dut (
    .core_clk(core_clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
    .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
    .sda_oe(sda_oe), .serial_irq(serial_irq), .wake_req(wake_req));
  iss_master_model mst (.scl(scl_w), .sda(sda_w), .scl_dn(scl_dn), .sda_dn(sda_dn));

  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    adr <= a;
    we  <= w;
    dat <= {24'h0, d};
    stb <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    stb <= 1'b0;
    if (n >= 16) begin
      fail_count++;
      $display("CHECK FAILED bus ack expected 1 seen 0");
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] v);
    notes.push_back({mk, v});
    wb(a, 1'b0, 8'h00);
  endtask

  task automatic hold(input logic v);
    int n;
    n = 0;
    while (scl_oe !== v && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("clock hold", v, scl_oe)
  endtask

  // read monitor: oldest note against the data seen with ack
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      `CHK("read data", {24'h0, nt.v & nt.mk}, wb_dat_o & {24'hFFFFFF, nt.mk})
    end
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'hC597));
    own = 7'($urandom());
    d0  = 8'($urandom());
    d1  = 8'($urandom());
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    rd(iss_pkg::OFS_STAT, 8'hFF, 8'h81);
    rd(iss_pkg::OFS_CTRL, 8'hFF, 8'hE0);
    wb(iss_pkg::OFS_STAT, 1'b1, 8'h18);
    wb(iss_pkg::OFS_CTRL, 1'b1, 8'hC2);
    rd(iss_pkg::OFS_STAT, 8'hFF, 8'h99);
    wb(iss_pkg::OFS_STAT, 1'b1, 8'h02);
    wb(iss_pkg::OFS_ADDR, 1'b1, {own, 1'b1});
    wb(iss_pkg::OFS_IRQ, 1'b1, 8'h01);
    wb(8'h18, 1'b1, 8'hFF);
    rd(8'h18, 8'hFF, 8'h00);
    // foreign address: no acknowledge, bus busy until stop
    mst.start();
    mst.send({own ^ 7'h01, 1'b0});
    mst.bit_clk(1'b1, s);
    `CHK("foreign nack", 1'b1, s)
    rd(iss_pkg::OFS_STAT, 8'h60, 8'h20);
    `CHK("irq idle", 1'b0, serial_irq)
    mst.stop();
    rd(iss_pkg::OFS_STAT, 8'h20, 8'h00);
    // master writes two bytes, the second refused
    mst.start();
    mst.send({own, 1'b0});
    mst.bit_clk(1'b1, s);
    `CHK("addr ack", 1'b0, s)
    hold(1'b1);
    `CHK("irq match", 1'b1, serial_irq)
    `CHK("wake", 1'b1, wake_req)
    rd(iss_pkg::OFS_STAT, 8'hE6, 8'h62);
    wb(iss_pkg::OFS_STAT, 1'b1, 8'h00);
    `CHK("wake off", 1'b0, wake_req)
    wb(iss_pkg::OFS_IRQ, 1'b1, 8'h03);
    `CHK("irq cleared", 1'b0, serial_irq)
    rd(iss_pkg::OFS_DATA, 8'h00, 8'h00);
    hold(1'b0);
    mst.send(d0);
    rd(iss_pkg::OFS_STAT, 8'h80, 8'h80);
    `CHK("irq byte", 1'b1, serial_irq)
    rd(iss_pkg::OFS_DATA, 8'hFF, d0);
    mst.bit_clk(1'b1, s);
    `CHK("data ack", 1'b0, s)
    // the ninth fall reaches the flags only after the pin synchroniser
    repeat (4) @(posedge core_clk);
    rd(iss_pkg::OFS_STAT, 8'h80, 8'h00);
    wb(iss_pkg::OFS_STAT, 1'b1, 8'h08);
    mst.send(d1);
    mst.bit_clk(1'b1, s);
    `CHK("data nack", 1'b1, s)
    mst.stop();
    // master reads: first byte acknowledged, second refused
    wb(iss_pkg::OFS_STAT, 1'b1, 8'h00);
    mst.start();
    mst.send({own, 1'b1});
    mst.bit_clk(1'b1, s);
    `CHK("read addr ack", 1'b0, s)
    hold(1'b1);
    rd(iss_pkg::OFS_STAT, 8'h44, 8'h44);
    wb(iss_pkg::OFS_STAT, 1'b1, 8'h10);
    wb(iss_pkg::OFS_DATA, 1'b1, ~d0);
    hold(1'b0);
    mst.recv(b);
    `CHK("sent byte", ~d0, b)
    mst.bit_clk(1'b0, s);
    rd(iss_pkg::OFS_STAT, 8'h01, 8'h00);
    mst.recv(b);
    mst.bit_clk(1'b1, s);
    rd(iss_pkg::OFS_STAT, 8'h01, 8'h01);
    repeat (8) @(posedge core_clk);
    `CHK("data released", 1'b0, sda_oe)
    mst.stop();
    rd(iss_pkg::OFS_STAT, 8'h20, 8'h00);
    // clock held too long after a match
    wb(iss_pkg::OFS_IRQ, 1'b1, 8'h03);
    wb(iss_pkg::OFS_TOC, 1'b1, 8'h81);
    mst.start();
    mst.send({own, 1'b0});
    mst.bit_clk(1'b1, s);
    repeat (2 * TO + 20) @(posedge core_clk);
    rd(iss_pkg::OFS_STAT, 8'hFF, 8'h81);
    rd(iss_pkg::OFS_TOC, 8'hC0, 8'h40);
    `CHK("irq timeout", 1'b1, serial_irq)
    mst.stop();
    close_out();
  end
endmodule
`default_nettype wire
